// >>> logic/palette_pkg.sv
package palette_pkg;
  // I/O port addresses of the palette registers
  localparam logic [15:0] PIXEL_INDEX_MASK_ADDR = 16'h03C6;
  localparam logic [15:0] PALETTE_READ_INDEX_ADDR = 16'h03C7;
  localparam logic [15:0] PALETTE_WRITE_INDEX_ADDR = 16'h03C8;
  localparam logic [15:0] PALETTE_DATA_PORT_ADDR = 16'h03C9;
  // Reset values
  localparam logic [7:0] PIXEL_INDEX_MASK_RST = 8'h00;
  localparam logic [7:0] READ_INDEX_RST = 8'h00;
  localparam logic [7:0] WRITE_INDEX_RST = 8'h00;
  localparam logic [7:0] DATA_PORT_RST = 8'h00;
  // Direction codes returned by a read of the read-index register
  localparam logic [7:0] DIR_WRITE_MODE = 8'h00;
  localparam logic [7:0] DIR_READ_MODE = 8'h03;
  // Component widths, entry count and component codes
  localparam int NARROW_BITS = 6;
  localparam int WIDE_BITS = 8;
  localparam int ENTRY_COUNT = 256;
  typedef enum logic [1:0] {
    COMP_RED,
    COMP_GREEN,
    COMP_BLUE
  } component_t;
endpackage : palette_pkg

// >>> logic/palette_entry_ram.sv
// Colour table: one write port, two read ports, flip-flop storage
module palette_entry_ram
  import palette_pkg::*;
#(
  parameter int DEPTH = ENTRY_COUNT,
  parameter int AW = 8
)(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  // Write port
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_index_i,
  input wire logic [1:0] wr_comp_i,
  input wire logic [7:0] wr_data_i,
  // Host read port
  input wire logic [AW-1:0] rd_index_i,
  output logic [23:0] rd_entry_o,
  // Pixel lookup port
  input wire logic [AW-1:0] px_index_i,
  output logic [23:0] px_entry_o
);
  logic [23:0] mem_reg [DEPTH];

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_reg[i] <= 24'h000000;
    end
    else if (clk_en_i && wr_en_i)
    begin
      unique case (wr_comp_i)
        2'h0: mem_reg[wr_index_i][23:16] <= wr_data_i;
        2'h1: mem_reg[wr_index_i][15:8] <= wr_data_i;
        default: mem_reg[wr_index_i][7:0] <= wr_data_i;
      endcase
    end
  end

  assign rd_entry_o = mem_reg[rd_index_i];
  assign px_entry_o = mem_reg[px_index_i];
endmodule : palette_entry_ram

// >>> logic/vga_palette_access_port.sv
// Overview of operation
// - Data port steps red, green, blue, then moves to the next entry.
// - Write-index write selects entry; index advances after every third data write.
// - Read-index write selects entry; index advances after every third data read.
// - Reading read-index gives 0 after write-index written, 3 after read-index.
// - Each mask bit keeps (1) or drops (0) its pixel index bit.
// - Mask applies only when extended display enable is low.
// - Wide-component enable selects 8-bit or 6-bit component transfers.
// - Legacy-port enable keeps palette reachable while extended display active.
module vga_palette_access_port
  import palette_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic clk_en_i,
  // Legacy I/O port
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [15:0] io_addr_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  output logic io_ack_o,
  // Mode controls
  input wire logic extended_display_enable_i,
  input wire logic legacy_port_palette_enable_i,
  input wire logic wide_component_enable_i,
  // Pixel lookup
  input wire logic [7:0] pixel_index_i,
  output logic [23:0] pixel_colour_o
);
  ////////////////////////////////////////////////////////////////////////////
  logic [1:0] rst_sync_reg;
  logic rst_n;

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rst_sync_reg <= 2'b00;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [7:0] mask;
    logic [7:0] rd_index;
    logic [7:0] wr_index;
    component_t rd_comp;
    component_t wr_comp;
    logic read_mode;
    logic [7:0] rdata;
    logic ack;
    logic [23:0] colour;
  } state_t;

  state_t state_reg;
  state_t state_next;
  logic port_open;
  logic sel_mask;
  logic sel_ridx;
  logic sel_widx;
  logic sel_data;
  logic data_wr;
  logic data_rd;
  logic [7:0] comp_in;
  logic [7:0] comp_out;
  logic [7:0] lookup_index;
  logic [23:0] rd_entry;
  logic [23:0] px_entry;

  assign port_open = !extended_display_enable_i || legacy_port_palette_enable_i;
  assign sel_mask = port_open && (io_addr_i == PIXEL_INDEX_MASK_ADDR);
  assign sel_ridx = port_open && (io_addr_i == PALETTE_READ_INDEX_ADDR);
  assign sel_widx = port_open && (io_addr_i == PALETTE_WRITE_INDEX_ADDR);
  assign sel_data = port_open && (io_addr_i == PALETTE_DATA_PORT_ADDR);
  assign data_wr = clk_en_i && io_wr_i && sel_data;
  assign data_rd = clk_en_i && io_rd_i && !io_wr_i && sel_data;

  // Narrow values sit in the low six bits and are scaled up on store
  assign comp_in = wide_component_enable_i ? io_wdata_i
                                           : {io_wdata_i[NARROW_BITS-1:0], 2'b00};

  always_comb
  begin
    unique case (state_reg.rd_comp)
      COMP_RED: comp_out = rd_entry[23:16];
      COMP_GREEN: comp_out = rd_entry[15:8];
      default: comp_out = rd_entry[7:0];
    endcase
    if (!wide_component_enable_i)
      comp_out = {2'b00, comp_out[WIDE_BITS-1:2]};
  end

  assign lookup_index = extended_display_enable_i ? pixel_index_i
                                                  : (pixel_index_i & state_reg.mask);

  palette_entry_ram #(
    .DEPTH(ENTRY_COUNT),
    .AW(8)
  ) u_ram (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n),
    .clk_en_i(clk_en_i),
    .wr_en_i(data_wr),
    .wr_index_i(state_reg.wr_index),
    .wr_comp_i(state_reg.wr_comp),
    .wr_data_i(comp_in),
    .rd_index_i(state_reg.rd_index),
    .rd_entry_o(rd_entry),
    .px_index_i(lookup_index),
    .px_entry_o(px_entry)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    state_next = state_reg;
    state_next.ack = 1'b0;
    state_next.colour = px_entry;
    if (io_wr_i)
    begin
      state_next.ack = 1'b1;
      if (sel_mask)
        state_next.mask = io_wdata_i;
      if (sel_ridx)
      begin
        state_next.rd_index = io_wdata_i;
        state_next.rd_comp = COMP_RED;
        state_next.read_mode = 1'b1;
      end
      if (sel_widx)
      begin
        state_next.wr_index = io_wdata_i;
        state_next.wr_comp = COMP_RED;
        state_next.read_mode = 1'b0;
      end
      if (sel_data)
      begin
        unique case (state_reg.wr_comp)
          COMP_RED: state_next.wr_comp = COMP_GREEN;
          COMP_GREEN: state_next.wr_comp = COMP_BLUE;
          default:
          begin
            state_next.wr_comp = COMP_RED;
            state_next.wr_index = state_reg.wr_index + 8'h01;
          end
        endcase
      end
    end
    else if (io_rd_i)
    begin
      state_next.ack = 1'b1;
      state_next.rdata = 8'h00;
      if (sel_mask)
        state_next.rdata = state_reg.mask;
      if (sel_ridx)
        state_next.rdata = state_reg.read_mode ? DIR_READ_MODE : DIR_WRITE_MODE;
      if (sel_widx)
        state_next.rdata = state_reg.wr_index;
      if (sel_data)
      begin
        state_next.rdata = comp_out;
        unique case (state_reg.rd_comp)
          COMP_RED: state_next.rd_comp = COMP_GREEN;
          COMP_GREEN: state_next.rd_comp = COMP_BLUE;
          default:
          begin
            state_next.rd_comp = COMP_RED;
            state_next.rd_index = state_reg.rd_index + 8'h01;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= '{mask: PIXEL_INDEX_MASK_RST, rd_index: READ_INDEX_RST,
                     wr_index: WRITE_INDEX_RST, rd_comp: COMP_RED, wr_comp: COMP_RED,
                     read_mode: 1'b0, rdata: DATA_PORT_RST, ack: 1'b0,
                     colour: 24'h000000};
    end
    else if (clk_en_i)
    begin
      state_reg <= state_next;
    end
  end

  assign io_rdata_o = state_reg.rdata;
  assign io_ack_o = state_reg.ack;
  assign pixel_colour_o = state_reg.colour;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_wr_advance;
    @(posedge clk_sys_i) disable iff (!rst_n)
    (data_wr && state_reg.wr_comp == COMP_BLUE)
      |=> (state_reg.wr_index == $past(state_reg.wr_index) + 8'h01);
  endproperty
  a_wr_advance: assert property (p_wr_advance) else $error("write index no advance");

  property p_rd_advance;
    @(posedge clk_sys_i) disable iff (!rst_n)
    (data_rd && state_reg.rd_comp == COMP_BLUE)
      |=> (state_reg.rd_index == $past(state_reg.rd_index) + 8'h01);
  endproperty
  a_rd_advance: assert property (p_rd_advance) else $error("read index no advance");

  property p_wr_hold;
    @(posedge clk_sys_i) disable iff (!rst_n)
    (data_wr && state_reg.wr_comp != COMP_BLUE && !(io_wr_i && sel_widx))
      |=> $stable(state_reg.wr_index);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write index moved early");

  property p_dir_read;
    @(posedge clk_sys_i) disable iff (!rst_n)
    (clk_en_i && io_wr_i && sel_ridx) ##1 !(clk_en_i && io_wr_i && sel_widx)
      ##1 (clk_en_i && io_rd_i && !io_wr_i && sel_ridx)
      |=> (io_rdata_o == DIR_READ_MODE);
  endproperty
  a_dir_read: assert property (p_dir_read) else $error("direction not 3");

  property p_dir_write;
    @(posedge clk_sys_i) disable iff (!rst_n)
    (clk_en_i && io_rd_i && !io_wr_i && sel_ridx && !state_reg.read_mode)
      |=> (io_rdata_o == DIR_WRITE_MODE);
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction not 0");

  property p_mask_gate;
    @(posedge clk_sys_i) disable iff (!rst_n)
    !extended_display_enable_i |-> ((lookup_index & ~state_reg.mask) == 8'h00);
  endproperty
  a_mask_gate: assert property (p_mask_gate) else $error("masked bit used");

  property p_mask_ext;
    @(posedge clk_sys_i) disable iff (!rst_n)
    extended_display_enable_i |-> (lookup_index == pixel_index_i);
  endproperty
  a_mask_ext: assert property (p_mask_ext) else $error("mask applied in extended");

  property p_narrow;
    @(posedge clk_sys_i) disable iff (!rst_n)
    (data_rd && !wide_component_enable_i) |=> (io_rdata_o[7:6] == 2'b00);
  endproperty
  a_narrow: assert property (p_narrow) else $error("narrow read wide");

  property p_closed;
    @(posedge clk_sys_i) disable iff (!rst_n)
    (clk_en_i && io_wr_i && extended_display_enable_i && !legacy_port_palette_enable_i)
      |=> $stable(state_reg.wr_index) && $stable(state_reg.mask);
  endproperty
  a_closed: assert property (p_closed) else $error("port open in extended");

  property p_wrap;
    @(posedge clk_sys_i) disable iff (!rst_n)
    (data_wr && state_reg.wr_comp == COMP_BLUE && state_reg.wr_index == 8'hFF)
      |=> (state_reg.wr_index == 8'h00);
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap");

  // Host leaves one idle cycle between accesses
  c_triple_wr: cover property (@(posedge clk_sys_i) disable iff (!rst_n)
    data_wr ##2 data_wr ##2 data_wr);
  c_triple_rd: cover property (@(posedge clk_sys_i) disable iff (!rst_n)
    data_rd ##2 data_rd ##2 data_rd);
  c_legacy_ext: cover property (@(posedge clk_sys_i) disable iff (!rst_n)
    data_wr && extended_display_enable_i);
endmodule : vga_palette_access_port

// >>> test/io_host.sv
// Host side of the legacy I/O port: one strobe cycle per access, then waits for ack
module io_host
(
  // Clock
  input wire logic clk_sys_i,
  // Answer from the device
  input wire logic io_ack_i,
  input wire logic [7:0] io_rdata_i,
  // Request to the device
  output logic io_wr_o,
  output logic io_rd_o,
  output logic [15:0] io_addr_o,
  output logic [7:0] io_wdata_o,
  // Bench status
  output logic timeout_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    io_wr_o = 1'b0;
    io_rd_o = 1'b0;
    io_addr_o = 16'h0000;
    io_wdata_o = 8'h00;
    timeout_o = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Strobe is a level, so it drops after the taking edge to avoid a second access
  task automatic access(input logic wr, input logic [15:0] addr, input logic [7:0] wdata,
                        output logic [7:0] rdata);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    #1;
    io_wr_o = wr;
    io_rd_o = !wr;
    io_addr_o = addr;
    io_wdata_o = wr ? wdata : ~io_wdata_o;
    @(posedge clk_sys_i);
    #1;
    io_wr_o = 1'b0;
    io_rd_o = 1'b0;
    // Released lines show a changed value, never the last one
    io_addr_o = ~addr;
    io_wdata_o = ~io_wdata_o;
    while (io_ack_i !== 1'b1 && n < 8)
    begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    if (n == 8)
      timeout_o = 1'b1;
    rdata = io_rdata_i;
  endtask : access
endmodule : io_host

// >>> test/vga_palette_access_port_tb.sv
module vga_palette_access_port_tb
  import palette_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic io_wr;
  logic io_rd;
  logic [15:0] io_addr;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  logic io_ack;
  logic host_timeout;
  logic ext_en = 1'b0;
  logic legacy_en = 1'b0;
  logic wide_en = 1'b1;
  logic [7:0] pixel_index = 8'h00;
  logic [23:0] pixel_colour;
  logic [23:0] pal [ENTRY_COUNT];
  logic [7:0] mask = 8'h00;
  logic [31:0] seed = 32'h0000C4AE;
  int n_mismatch = 0;
  int checked = 0;

  always #2.5 clk_sys = ~clk_sys;

  io_host host (.clk_sys_i(clk_sys), .io_ack_i(io_ack), .io_rdata_i(io_rdata),
    .io_wr_o(io_wr), .io_rd_o(io_rd), .io_addr_o(io_addr), .io_wdata_o(io_wdata),
    .timeout_o(host_timeout));

  vga_palette_access_port dut (.clk_sys_i(clk_sys), .arst_n_i(arst_n), .clk_en_i(1'b1),
    .io_wr_i(io_wr), .io_rd_i(io_rd), .io_addr_i(io_addr), .io_wdata_i(io_wdata),
    .io_rdata_o(io_rdata), .io_ack_o(io_ack), .extended_display_enable_i(ext_en),
    .legacy_port_palette_enable_i(legacy_en), .wide_component_enable_i(wide_en),
    .pixel_index_i(pixel_index), .pixel_colour_o(pixel_colour));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd

  // Narrow components sit in the top six bits of the table
  function automatic logic [7:0] stored(input logic [7:0] v);
    return wide_en ? v : {v[5:0], 2'b00};
  endfunction : stored

  function automatic logic [7:0] read_back(input logic [7:0] s);
    return wide_en ? s : {2'b00, s[7:2]};
  endfunction : read_back

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude

  ////////////////////////////////////////////////////////////////////////////////
  task automatic acc(input logic wr, input logic [15:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    host.access(wr, a, d, q);
    if (host_timeout === 1'b1)
    begin
      n_mismatch++;
      conclude();
    end
  endtask : acc

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] q;
    acc(1'b1, a, d, q);
  endtask : wr

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] q;
    acc(1'b0, a, 8'h00, q);
    check({16'h0000, q}, {16'h0000, exp});
  endtask : rd_chk

  task automatic wr_run(input logic [7:0] start, input int n);
    logic [7:0] v;
    wr(PALETTE_WRITE_INDEX_ADDR, start);
    rd_chk(PALETTE_READ_INDEX_ADDR, DIR_WRITE_MODE);
    for (int k = 0; k < n * 3; k++)
    begin
      v = rnd();
      wr(PALETTE_DATA_PORT_ADDR, v);
      pal[8'(start + k / 3)][8 * (2 - k % 3) +: 8] = stored(v);
    end
    rd_chk(PALETTE_WRITE_INDEX_ADDR, 8'(start + n));
  endtask : wr_run

  task automatic rd_run(input logic [7:0] start, input int n);
    logic [7:0] e;
    wr(PALETTE_READ_INDEX_ADDR, start);
    rd_chk(PALETTE_READ_INDEX_ADDR, DIR_READ_MODE);
    for (int k = 0; k < n * 3; k++)
    begin
      e = read_back(pal[8'(start + k / 3)][8 * (2 - k % 3) +: 8]);
      rd_chk(PALETTE_DATA_PORT_ADDR, e);
    end
  endtask : rd_run

  task automatic px(input logic [7:0] p);
    pixel_index = p;
    repeat (2) @(posedge clk_sys);
    #1;
    check(pixel_colour, pal[ext_en ? p : p & mask]);
  endtask : px

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [7:0] s;
    for (int i = 0; i < ENTRY_COUNT; i++)
      pal[i] = 24'h000000;
    repeat (5) @(posedge clk_sys);
    #1;
    arst_n = 1'b1;
    repeat (2) @(posedge clk_sys);
    rd_chk(PIXEL_INDEX_MASK_ADDR, PIXEL_INDEX_MASK_RST);
    rd_chk(PALETTE_READ_INDEX_ADDR, DIR_WRITE_MODE);
    rd_chk(PALETTE_WRITE_INDEX_ADDR, WRITE_INDEX_RST);
    rd_chk(PALETTE_DATA_PORT_ADDR, DATA_PORT_RST);
    rd_chk(16'h03C5, 8'h00);
    wr_run(8'hFE, 3);
    rd_run(8'hFE, 3);
    for (int i = 0; i < 6; i++)
    begin
      wide_en = i[0];
      s = rnd();
      wr_run(s, i % 3 + 1);
      rd_run(s, i % 3 + 1);
    end
    wide_en = 1'b1;
    s = rnd();
    wr_run(s, ENTRY_COUNT);
    rd_run(s, ENTRY_COUNT);
    mask = rnd();
    wr(PIXEL_INDEX_MASK_ADDR, mask);
    rd_chk(PIXEL_INDEX_MASK_ADDR, mask);
    px(8'hFF);
    for (int i = 0; i < 6; i++)
      px(rnd());
    ext_en = 1'b1;
    legacy_en = 1'b1;
    for (int i = 0; i < 6; i++)
      px(rnd());
    rd_chk(PIXEL_INDEX_MASK_ADDR, mask);
    // Palette traffic through the legacy ports in extended mode
    s = rnd();
    wr_run(s, 1);
    rd_run(s, 1);
    legacy_en = 1'b0;
    wr(PIXEL_INDEX_MASK_ADDR, ~mask);
    rd_chk(PIXEL_INDEX_MASK_ADDR, 8'h00);
    ext_en = 1'b0;
    rd_chk(PIXEL_INDEX_MASK_ADDR, mask);
    conclude();
  end
endmodule : vga_palette_access_port_tb
